// >>> design/filter_mode_control.v
// filter and clock mode control for a sigma-delta decimation path
// How it works
// [R01] halving control divides master clock by two
// [R02] host keeps halving zero for normal conversions
// [R03] host sets halving below 4.75 V calibration
// [R04] host uses chop, low rate for calibration
// [R05] single-cycle settle gives zero-latency settled result
// [R06] settle ignored: multi-channel or single conversion
// [R07] with fast filter, settle needs chopping
// [R08] sixty hertz notch added at 50 Hz notch
// [R09] 10-bit rate select sets rate and notch
// [R10] rate equals clock/1024/select, select 1..1023
`timescale 1ns/100ps
`include "filter_mode_regs.vh"

module filter_mode_control
#(
    parameter RATE_WIDTH = `RATE_WIDTH
)
(
    input  wire        clock,
    input  wire        rstn,
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    output reg         conversion_tick,
    output reg         zero_latency,
    output reg         notch_sixty,
    output reg         filter_clock_enable
);

// ****************************************************************
// registers
// ****************************************************************
reg  [12:0]           mode_reg;
reg  [3:0]            control_reg;
reg                   halve_phase;
reg  [9:0]            base_count;
reg  [RATE_WIDTH-1:0] rate_count;
reg                   ready_flag;
reg                   served;
reg  [31:0]           period_count;
reg  [31:0]           period_last;

wire [RATE_WIDTH-1:0] output_rate_select;
wire                  sixty_hertz_notch_enable;
wire                  mode_bit_eleven;
wire                  mode_bit_twelve;
wire [RATE_WIDTH-1:0] rate_eff;
wire                  filter_step;
wire                  settle_ok;
wire                  base_wrap;
wire                  rate_wrap;
wire                  request_seen;
wire                  write_commit;
wire                  status_read;

assign output_rate_select       = mode_reg[`RATE_LSB +: RATE_WIDTH]; // R09
assign sixty_hertz_notch_enable = mode_reg[`NOTCH_BIT];
assign mode_bit_eleven          = mode_reg[`SINGLE_CYCLE_BIT];
assign mode_bit_twelve          = mode_reg[`HALVE_BIT];

// a zero select behaves as the lowest legal value
assign rate_eff = (output_rate_select == {RATE_WIDTH{1'b0}}) ?
                  `RATE_MIN : output_rate_select; // R10

// filter logic advances every clock, or every other when halved
assign filter_step = mode_bit_twelve ? halve_phase : 1'b1; // R01

// single-cycle settle only honoured in permitted configurations
assign settle_ok = mode_bit_eleven
                 & ~control_reg[`MULTI_CHAN_BIT]
                 & ~control_reg[`ONE_SHOT_BIT] // R06
                 & (~control_reg[`FAST_BIT]
                    | control_reg[`CHOP_BIT]); // R07

assign base_wrap = filter_step && (base_count == 10'h3FF);
// a count left beyond a smaller new select wraps at the next base wrap
assign rate_wrap = base_wrap && (rate_count >= rate_eff - 1'b1); // R10

// a request is seen once; a write lands at the answering edge
assign request_seen = (read | write) & waitrequest & ~served;
assign write_commit = write & ~waitrequest;
assign status_read  = request_seen & read
                    & (address == `STATUS_REG_ADDR);

// ****************************************************************
// avalon slave: one wait state then answer
// ****************************************************************
always @(posedge clock)
begin
    if (!rstn)
    begin
        waitrequest <= 1'b1;
        served      <= 1'b0;
    end
    else
    begin
        waitrequest <= ~request_seen;
        served      <= request_seen;
    end
end

// ****************************************************************
// register writes
// ****************************************************************
always @(posedge clock)
begin
    if (!rstn)
    begin
        mode_reg    <= `MODE_RESET;
        control_reg <= 4'h0;
    end
    else if (write_commit)
    begin
        case (address)
            `MODE_REG_ADDR:
                mode_reg <= writedata[12:0];
            `CONTROL_REG_ADDR:
                control_reg <= writedata[3:0];
            default:
                ;
        endcase
    end
end

// ****************************************************************
// read data, captured when the request is seen
// ****************************************************************
always @(posedge clock)
begin
    if (!rstn)
    begin
        readdata <= 32'h00000000;
    end
    else if (request_seen)
    begin
        case (address)
            `MODE_REG_ADDR:
                readdata <= {19'h00000, mode_reg};
            `CONTROL_REG_ADDR:
                readdata <= {28'h0000000, control_reg};
            `STATUS_REG_ADDR:
                readdata <= {28'h0000000, notch_sixty,
                             zero_latency, mode_bit_twelve,
                             ready_flag};
            `PERIOD_REG_ADDR:
                readdata <= period_last;
            default:
                readdata <= 32'h00000000;
        endcase
    end
end

// ****************************************************************
// mode outputs
// ****************************************************************
always @(posedge clock)
begin
    if (!rstn)
    begin
        halve_phase         <= 1'b0;
        filter_clock_enable <= 1'b0;
        zero_latency        <= 1'b0;
        notch_sixty         <= 1'b0;
    end
    else
    begin
        halve_phase         <= ~halve_phase; // R01
        filter_clock_enable <= filter_step; // R01
        zero_latency        <= settle_ok; // R05
        notch_sixty         <= sixty_hertz_notch_enable; // R08
    end
end

// ****************************************************************
// decimation timing
// ****************************************************************
always @(posedge clock)
begin
    if (!rstn)
    begin
        base_count      <= 10'h000;
        rate_count      <= {RATE_WIDTH{1'b0}};
        conversion_tick <= 1'b0;
    end
    else
    begin
        conversion_tick <= rate_wrap; // R09
        if (base_wrap)
        begin
            base_count <= 10'h000;
            if (rate_wrap)
                rate_count <= {RATE_WIDTH{1'b0}};
            else
                rate_count <= rate_count + 1'b1;
        end
        else if (filter_step)
        begin
            base_count <= base_count + 10'h001;
        end
    end
end

// ****************************************************************
// period measurement
// ****************************************************************
always @(posedge clock)
begin
    if (!rstn)
    begin
        period_count <= 32'h00000000;
        period_last  <= 32'h00000000;
    end
    else if (rate_wrap)
    begin
        period_last  <= period_count + 32'h00000001;
        period_count <= 32'h00000000;
    end
    else
    begin
        period_count <= period_count + 32'h00000001;
    end
end

// ****************************************************************
// ready flag: hardware set wins over a status read clear
// ****************************************************************
always @(posedge clock)
begin
    if (!rstn)
        ready_flag <= 1'b0;
    else if (rate_wrap)
        ready_flag <= 1'b1;
    else if (status_read)
        ready_flag <= 1'b0;
end

endmodule

// >>> common/filter_mode_regs.vh
// register offsets, field positions and timing counts for filter mode control
`ifndef FILTER_MODE_REGS_VH
`define FILTER_MODE_REGS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define MODE_REG_ADDR        4'h0
`define CONTROL_REG_ADDR     4'h4
`define STATUS_REG_ADDR      4'h8
`define PERIOD_REG_ADDR      4'hC

// ****************************************************************
// mode register fields
// ****************************************************************
`define RATE_LSB             0
`define RATE_WIDTH           10
`define NOTCH_BIT            10
`define SINGLE_CYCLE_BIT     11
`define HALVE_BIT            12
`define MODE_WRITE_MASK      32'h00001FFF
`define MODE_RESET           13'h0001

// ****************************************************************
// control register fields
// ****************************************************************
`define CHOP_BIT             0
`define FAST_BIT             1
`define ONE_SHOT_BIT         2
`define MULTI_CHAN_BIT       3
`define CONTROL_WRITE_MASK   32'h0000000F

// ****************************************************************
// status register fields
// ****************************************************************
`define STATUS_READY_BIT     0
`define STATUS_HALVED_BIT    1
`define STATUS_ZERO_LAT_BIT  2
`define STATUS_NOTCH_BIT     3

// ****************************************************************
// timing
// ****************************************************************
`define BASE_DIVIDE          11'h400
`define CLOCK_HALVING        2
`define RATE_MIN             10'h001

`endif

// >>> test/filter_mode_control_sva.sv
// port assertions for the filter mode control block
`timescale 1ns/100ps
module filter_mode_control_sva
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic conversion_tick,
    input wire logic zero_latency,
    input wire logic notch_sixty
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wait_once_a: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than one cycle");
    wait_cause_a: assert property (!waitrequest |-> $past(read || write))
        else $error("answer without request");
    answer_soon_a: assert property
        ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
        else $error("request not answered");
    reset_idle_a: assert property ($rose(rstn) |->
        waitrequest && !conversion_tick && !zero_latency && !notch_sixty)
        else $error("outputs not idle after reset");
    tick_pulse_a: assert property (conversion_tick |=> !conversion_tick)
        else $error("tick longer than one cycle");
    tick_gap_a: assert property (conversion_tick |=> !conversion_tick[*8])
        else $error("ticks too close");
    latency_hold_a: assert property ($changed(zero_latency) |->
        $past(write && !waitrequest) || $past(write && !waitrequest, 2))
        else $error("settle state changed without write");
    notch_hold_a: assert property ($changed(notch_sixty) |->
        $past(write && !waitrequest) || $past(write && !waitrequest, 2))
        else $error("notch changed without write");
endmodule

bind filter_mode_control filter_mode_control_sva i_sva (.clock(clock),
    .rstn(rstn), .read(read), .write(write), .waitrequest(waitrequest),
    .conversion_tick(conversion_tick), .zero_latency(zero_latency),
    .notch_sixty(notch_sixty));

// >>> test/filter_mode_control_test.sv
// self-checking bench for the filter mode control block
`timescale 1ns/100ps
`include "filter_mode_regs.vh"
module filter_mode_control_test;
    logic        clock = 0;
    logic        rstn = 0;
    logic [3:0]  address = 0;
    logic        read = 0;
    logic        write = 0;
    logic [31:0] writedata = 0;
    wire  [31:0] readdata;
    wire         waitrequest, conversion_tick, zero_latency, notch_sixty;
    wire         filter_clock_enable;
    logic [31:0] exp_q[$], msk_q[$], seed = 32'hEB843AD7;
    logic [9:0]  sel;
    logic        zl;
    int          n_fail = 0, checked = 0, k, st;
    filter_mode_control i_dut (.clock(clock), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .conversion_tick(conversion_tick), .zero_latency(zero_latency),
        .notch_sixty(notch_sixty),
        .filter_clock_enable(filter_clock_enable));
    initial forever #5 clock = !clock;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want)
        begin
            n_fail++;
            $display("wrong value at %0t: %h %h", $time, got, want);
        end
    endtask
    task automatic summarize;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus(input logic r, input logic [3:0] a, input [31:0] d);
        int i;
        @(posedge clock);
        read <= r;
        write <= !r;
        address <= a;
        writedata <= d;
        for (i = 0; i < 50 && waitrequest !== 1'b0; i++)
            @(posedge clock);
        read <= 0;
        write <= 0;
        if (i == 50)
        begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic rd(input logic [3:0] a, input [31:0] e, input [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1, a, 0);
    endtask
    task automatic ticks(input int n, output int steps);
        int i;
        steps = 0;
        for (i = 0; i < 30000 && n > 0; i++)
        begin
            @(posedge clock);
            if (n == 1 && filter_clock_enable === 1'b1)
                steps++;
            if (conversion_tick === 1'b1)
                n--;
        end
        if (n > 0)
        begin
            n_fail++;
            summarize();
        end
    endtask
    always @(posedge clock)
        if (read && waitrequest === 1'b0)
            cmp(readdata & msk_q.pop_front(), exp_q.pop_front());
    initial
    begin
        repeat (100000) @(posedge clock);
        n_fail++;
        summarize();
    end
    initial
    begin
        repeat (6) @(posedge clock);
        rstn <= 1;
        rd(`MODE_REG_ADDR, 32'h1, '1);
        bus(0, 4'h2, '1);
        rd(4'h2, 0, '1);
        rd(`CONTROL_REG_ADDR, 0, '1);
        for (k = 0; k < 16; k++)
        begin
            seed = lfsr(seed);
            zl = !k[3] && !k[2] && (!k[1] || k[0]);
            bus(0, `CONTROL_REG_ADDR, k);
            bus(0, `MODE_REG_ADDR, {seed[31:13], 2'b01, k[0], 10'h001});
            rd(`MODE_REG_ADDR, {19'h0, 2'b01, k[0], 10'h001}, '1);
            rd(`STATUS_REG_ADDR, {k[0], zl, 2'b00}, 32'hE);
            cmp({zero_latency, notch_sixty}, {zl, k[0]});
        end
        for (k = 0; k < 3; k++)
        begin
            seed = lfsr(seed);
            sel = k == 0 ? 10'h0 : k == 1 ? 10'h1 : seed[1:0] + 10'h1;
            bus(0, `CONTROL_REG_ADDR, k == 1);
            bus(0, `MODE_REG_ADDR, {19'h0, k == 1, 2'b00, sel});
            ticks(2, st);
            cmp(st, (sel | (sel == 0)) * 1024);
            rd(`PERIOD_REG_ADDR, (sel | (sel == 0)) * 1024 * (1 + (k == 1)),
                '1);
            rd(`STATUS_REG_ADDR, {k == 1, 1'b1}, 32'h3);
            rd(`STATUS_REG_ADDR, {k == 1, 1'b0}, 32'h3);
        end
        summarize();
    end
endmodule
